// >>> rgc_gain_loop.sv
// Gain control loop: magnitude averaging, gain stepping, second-amp
// switching and the AXI4-Lite register slave.
// Assumes magnitude samples and rx_on come from logic on clk.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rgc_gain_loop #(
  parameter int CNT_W = 4
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [rgc_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                      wvalid,
  output logic                           wready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  output logic                           bvalid,
  input  wire logic                      bready,
  output logic [1:0]                     bresp,
  input  wire logic                      arvalid,
  output logic                           arready,
  input  wire logic [rgc_pkg::AXI_AW-1:0] araddr,
  output logic                           rvalid,
  input  wire logic                      rready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  input  wire logic                      rx_on,
  input  wire logic                      mag_valid,
  input  wire logic [rgc_pkg::MAG_W-1:0] mag_level,
  output logic [4:0]                     vga_gain,
  output logic [1:0]                     lna2_gain,
  output logic [rgc_pkg::MAG_W-1:0]      avg_level,
  output logic                           avg_valid
);

  localparam int MW = rgc_pkg::MAG_W;
  localparam int AW = MW + CNT_W;

  if (CNT_W < 4) begin : g_chk
    $error("CNT_W must count at least 16 samples");
  end

  // Address decode: misaligned addresses set the top bit and miss
  function automatic logic [6:0] dec(input logic [rgc_pkg::AXI_AW-1:0] a);
    return {a[1:0] != 2'h0, a[rgc_pkg::AXI_AW-1:2]};
  endfunction

  rgc_pkg::rgc_setup_t setup_q, setup_d;
  rgc_pkg::rgc_step_t  step_q, step_d;
  rgc_pkg::rgc_ref_t   ref_q, ref_d;
  rgc_pkg::rgc_stat_t  stat;

  logic                      aw_have_q, aw_have_d;
  logic [rgc_pkg::AXI_AW-1:0] aw_addr_q, aw_addr_d;
  logic                      w_have_q, w_have_d;
  logic [7:0]                w_byte_q, w_byte_d;
  logic                      w_en_q, w_en_d;
  logic                      awready_q, awready_d;
  logic                      wready_q, wready_d;
  logic                      bvalid_q, bvalid_d;
  logic [1:0]                bresp_q, bresp_d;
  logic                      arready_q, arready_d;
  logic                      rvalid_q, rvalid_d;
  logic [31:0]               rdata_q, rdata_d;
  logic [1:0]                rresp_q, rresp_d;

  logic [AW-1:0]    acc_q, acc_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [MW-1:0]    avg_q, avg_d;
  logic             done_q, done_d;
  logic [4:0]       vga_gain_q, vga_gain_d;
  logic [1:0]       lna2_q, lna2_d;
  rgc_pkg::rgc_hy_t hy_q, hy_d;

  logic [MW:0] up_th;
  logic [MW:0] dn_th;
  logic        call_up;
  logic        call_dn;

  assign stat = '{avg: avg_q, lna: lna2_q, gain: vga_gain_q};

  // Register bus
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_byte_d  = w_byte_q;
    w_en_d    = w_en_q;
    bvalid_d  = bvalid_q && !bready;
    bresp_d   = bresp_q;
    setup_d   = setup_q;
    step_d    = step_q;
    ref_d     = ref_q;
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_byte_d = wdata[7:0];
      w_en_d   = wstrb[0];
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = rgc_pkg::RESP_OKAY;
      case (dec(aw_addr_q))
        {1'b0, rgc_pkg::IDX_SETUP}: begin
          if (w_en_q) setup_d = w_byte_q;
        end
        {1'b0, rgc_pkg::IDX_STEP}: begin
          if (w_en_q) step_d = w_byte_q;
        end
        {1'b0, rgc_pkg::IDX_REF}: begin
          if (w_en_q) ref_d = w_byte_q;
        end
        {1'b0, rgc_pkg::IDX_STAT}: begin
          bresp_d = rgc_pkg::RESP_OKAY;
        end
        default: begin
          bresp_d = rgc_pkg::RESP_DECERR;
        end
      endcase
    end
    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
  end

  always_comb begin
    rvalid_d  = rvalid_q && !rready;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    arready_d = arready_q;
    if (arvalid && arready_q) begin
      rvalid_d  = 1'b1;
      arready_d = 1'b0;
      rresp_d   = rgc_pkg::RESP_OKAY;
      case (dec(araddr))
        {1'b0, rgc_pkg::IDX_SETUP}: rdata_d = 32'(setup_q);
        {1'b0, rgc_pkg::IDX_STEP}:  rdata_d = 32'(step_q);
        {1'b0, rgc_pkg::IDX_REF}:   rdata_d = 32'(ref_q);
        {1'b0, rgc_pkg::IDX_STAT}:  rdata_d = 32'(stat);
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = rgc_pkg::RESP_DECERR;
        end
      endcase
    end else if (rvalid_q && rready) begin
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q  <= 1'b0;
      w_byte_q  <= 8'h00;
      w_en_q    <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= rgc_pkg::RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= rgc_pkg::RESP_OKAY;
      setup_q   <= rgc_pkg::RST_SETUP;
      step_q    <= rgc_pkg::RST_STEP;
      ref_q     <= rgc_pkg::RST_REF;
    end else begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_byte_q  <= w_byte_d;
      w_en_q    <= w_en_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      setup_q   <= setup_d;
      step_q    <= step_d;
      ref_q     <= ref_d;
    end
  end

  // Magnitude averaging; a new length restarts the window so no
  // mixed-length average is ever reported
  always_comb begin
    logic [AW-1:0]    sum;
    logic [CNT_W-1:0] last;
    sum    = acc_q + AW'(mag_level);
    last   = CNT_W'((2 << setup_q.avg_len) - 1);
    acc_d  = acc_q;
    cnt_d  = cnt_q;
    avg_d  = avg_q;
    done_d = 1'b0;
    if (!rx_on || setup_d.avg_len != setup_q.avg_len) begin
      acc_d = '0;
      cnt_d = '0;
    end else if (mag_valid) begin
      if (cnt_q >= last) begin
        avg_d  = MW'(sum >> ({1'b0, setup_q.avg_len} + 3'h1));
        done_d = 1'b1;
        acc_d  = '0;
        cnt_d  = '0;
      end else begin
        acc_d = sum;
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  // Thresholds in 1.5 dB units above the carrier reference
  assign up_th   = (MW+1)'(ref_q.cs_level) + (MW+1)'(ref_q.up_margin);
  assign dn_th   = up_th + rgc_pkg::DOWN_BASE
                 + (MW+1)'(step_q.down_margin);
  assign call_up = {1'b0, avg_q} < up_th;
  assign call_dn = {1'b0, avg_q} > dn_th;

  always_comb begin
    logic [5:0] sw;
    sw         = rgc_pkg::SW_STEP_3;
    vga_gain_d = vga_gain_q;
    hy_d       = hy_q;
    if (!rx_on || setup_q.loop_off) begin
      vga_gain_d = step_q.start_gain;
      hy_d       = rgc_pkg::RGC_HY_IDLE;
    end else if (vga_gain_q > step_q.start_gain) begin
      vga_gain_d = step_q.start_gain;
    end else if (done_q) begin
      if (call_up && vga_gain_q < step_q.start_gain) begin
        if (!setup_q.hyst || hy_q == rgc_pkg::RGC_HY_UP) begin
          vga_gain_d = vga_gain_q + 5'h01;
          hy_d       = rgc_pkg::RGC_HY_IDLE;
        end else begin
          hy_d = rgc_pkg::RGC_HY_UP;
        end
      end else if (call_dn && vga_gain_q != 5'h00) begin
        if (!setup_q.hyst || hy_q == rgc_pkg::RGC_HY_DN) begin
          vga_gain_d = vga_gain_q - 5'h01;
          hy_d       = rgc_pkg::RGC_HY_IDLE;
        end else begin
          hy_d = rgc_pkg::RGC_HY_DN;
        end
      end else begin
        hy_d = rgc_pkg::RGC_HY_IDLE;
      end
    end
    case (setup_q.sw_point)
      2'h0:    sw = rgc_pkg::SW_STEP_0;
      2'h1:    sw = rgc_pkg::SW_STEP_1;
      2'h2:    sw = rgc_pkg::SW_STEP_2;
      default: sw = rgc_pkg::SW_STEP_3;
    endcase
    if ({1'b0, vga_gain_d} >= sw) begin
      lna2_d = setup_q.ceil_max ? rgc_pkg::LNA_MAX : rgc_pkg::LNA_MED;
    end else begin
      lna2_d = setup_q.floor_med ? rgc_pkg::LNA_MED : rgc_pkg::LNA_MIN;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q      <= '0;
      cnt_q      <= '0;
      avg_q      <= '0;
      done_q     <= 1'b0;
      vga_gain_q <= rgc_pkg::RST_STEP[4:0];
      lna2_q     <= rgc_pkg::LNA_MIN;
      hy_q       <= rgc_pkg::RGC_HY_IDLE;
    end else begin
      acc_q      <= acc_d;
      cnt_q      <= cnt_d;
      avg_q      <= avg_d;
      done_q     <= done_d;
      vga_gain_q <= vga_gain_d;
      lna2_q     <= lna2_d;
      hy_q       <= hy_d;
    end
  end

  assign awready   = awready_q;
  assign wready    = wready_q;
  assign bvalid    = bvalid_q;
  assign bresp     = bresp_q;
  assign arready   = arready_q;
  assign rvalid    = rvalid_q;
  assign rdata     = rdata_q;
  assign rresp     = rresp_q;
  assign vga_gain  = vga_gain_q;
  assign lna2_gain = lna2_q;
  assign avg_level = avg_q;
  assign avg_valid = done_q;

  // Checks
  logic [CNT_W:0] smp_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) smp_q <= '0;
    else if (!rx_on || setup_d.avg_len != setup_q.avg_len) smp_q <= '0;
    else smp_q <= (done_q ? '0 : smp_q) + (CNT_W+1)'(mag_valid);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_gain_ceiling: assert property (
    $stable(step_q) |-> vga_gain_q <= step_q.start_gain)
    else $error("gain above start gain");
  a_off_holds: assert property (
    setup_q.loop_off && $past(setup_q.loop_off) && $stable(step_q)
    |-> vga_gain_q == step_q.start_gain)
    else $error("gain moved while loop off");
  a_rx_start: assert property (
    $rose(rx_on) |=> vga_gain_q == $past(step_q.start_gain, 2))
    else $error("gain not at start gain on receive start");
  a_one_step: assert property (
    rx_on && !setup_q.loop_off && $stable(step_q) |=>
    5'(vga_gain_q - $past(vga_gain_q)) inside {5'h00, 5'h01, 5'h1F})
    else $error("gain moved more than one step");
  a_lna_floor: assert property (
    lna2_q == rgc_pkg::LNA_MIN |-> !$past(setup_q.floor_med))
    else $error("second amp below floor");
  a_lna_ceil: assert property (
    lna2_q == rgc_pkg::LNA_MAX |-> $past(setup_q.ceil_max))
    else $error("second amp above ceiling");
  a_lna_point: assert property (
    $past(setup_q.sw_point) == 2'h0 |-> lna2_q ==
    ($past(setup_q.ceil_max) ? rgc_pkg::LNA_MAX : rgc_pkg::LNA_MED))
    else $error("switch point code 0 not at high level");
  a_avg_count: assert property (
    done_q && $stable(setup_q) && $past(rx_on)
    |-> smp_q == (CNT_W+1)'(2 << setup_q.avg_len))
    else $error("wrong number of samples averaged");
  a_raise_low: assert property (
    done_q && rx_on && !setup_q.loop_off && !setup_q.hyst && call_up
    && vga_gain_q < step_q.start_gain
    |=> vga_gain_q == 5'($past(vga_gain_q) + 5'h01))
    else $error("gain not raised below up threshold");
  a_drop_high: assert property (
    done_q && rx_on && !setup_q.loop_off && !setup_q.hyst && call_dn
    && vga_gain_q != 5'h00 && vga_gain_q <= step_q.start_gain
    |=> vga_gain_q == 5'($past(vga_gain_q) - 5'h01))
    else $error("gain not lowered above down threshold");
  a_hyst_wait: assert property (
    done_q && rx_on && !setup_q.loop_off && setup_q.hyst && call_up
    && hy_q != rgc_pkg::RGC_HY_UP && vga_gain_q < step_q.start_gain
    |=> $stable(vga_gain_q))
    else $error("hysteresis stepped on first sample");

  c_gain_up: cover property (done_q ##1 $rose(vga_gain_q[0]));
  c_gain_down: cover property (done_q && call_dn ##1 $fell(vga_gain_q[0]));
  c_loop_off: cover property (setup_q.loop_off && rx_on);
  c_bad_addr: cover property (rvalid_q && rresp_q == rgc_pkg::RESP_DECERR);

endmodule

// >>> rgc_pkg.sv
// Register map, field layouts and constants of the receiver gain loop.
// Assumes an AXI4-Lite slave with 32-bit data; each register is one word.
// Overview of operation
// - Floor bit picks minimum or medium second-amplifier gain as lowest.
// - Ceiling bit picks medium or maximum second-amplifier gain as highest.
// - Switch-point code places second-amp change below 0, at 10, 19, above 31.
// - Loop-off bit freezes gain at the programmed start gain.
// - Hysteresis needs two averaged samples in a row before a step.
// - Averaging length code selects 2, 4, 8 or 16 magnitude samples.
// - Gain drops above reference plus up margin plus 4.5 to 15 dB.
// - Gain starts at the start gain field, reset 24, on receive start.
// - The loop never raises gain above the start gain field.
// - Gain rises below reference plus 0 to 10.5 dB in 1.5 dB steps.
// - Five-bit carrier reference, reset 24, is the common threshold.
package rgc_pkg;

  localparam int AXI_AW = 8;
  localparam int MAG_W  = 8;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_SETUP = 6'h12;
  localparam logic [5:0] IDX_STEP  = 6'h13;
  localparam logic [5:0] IDX_REF   = 6'h14;
  localparam logic [5:0] IDX_STAT  = 6'h18;

  localparam logic [7:0] RST_SETUP = 8'h75;
  localparam logic [7:0] RST_STEP  = 8'h38;
  localparam logic [7:0] RST_REF   = 8'h38;

  localparam logic [1:0] LNA_MIN = 2'h0;
  localparam logic [1:0] LNA_MED = 2'h1;
  localparam logic [1:0] LNA_MAX = 2'h2;

  // Gain steps where the second amplifier switches, per switch-point code
  localparam logic [5:0] SW_STEP_0 = 6'h00;
  localparam logic [5:0] SW_STEP_1 = 6'h0A;
  localparam logic [5:0] SW_STEP_2 = 6'h13;
  localparam logic [5:0] SW_STEP_3 = 6'h20;

  // Levels count in 1.5 dB units; 4.5 dB is three units
  localparam logic [MAG_W:0] DOWN_BASE = 9'h003;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic       floor_med;
    logic       ceil_max;
    logic [1:0] sw_point;
    logic       loop_off;
    logic       hyst;
    logic [1:0] avg_len;
  } rgc_setup_t;

  typedef struct packed {
    logic [2:0] down_margin;
    logic [4:0] start_gain;
  } rgc_step_t;

  typedef struct packed {
    logic [2:0] up_margin;
    logic [4:0] cs_level;
  } rgc_ref_t;

  typedef struct packed {
    logic [MAG_W-1:0] avg;
    logic [1:0]       lna;
    logic [4:0]       gain;
  } rgc_stat_t;

  typedef enum logic [1:0] {RGC_HY_IDLE, RGC_HY_UP, RGC_HY_DN} rgc_hy_t;

endpackage

// >>> test_receiver_gain_control_loop.sv
// Self-checking bench for the receiver gain loop: register access over
// AXI4-Lite, averaging, gain stepping and second-amplifier switching.
// Assumes rgc_pkg and rgc_gain_loop are compiled first.
`timescale 1ns/1ps
module test_receiver_gain_control_loop;
  localparam logic [7:0] A_SETUP = {rgc_pkg::IDX_SETUP, 2'h0};
  localparam logic [7:0] A_STEP  = {rgc_pkg::IDX_STEP, 2'h0};
  localparam logic [7:0] A_REF   = {rgc_pkg::IDX_REF, 2'h0};
  localparam logic [7:0] A_STAT  = {rgc_pkg::IDX_STAT, 2'h0};
  localparam logic [1:0] OK      = rgc_pkg::RESP_OKAY;
  localparam logic [1:0] DEC     = rgc_pkg::RESP_DECERR;

  logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic        rx_on, mag_valid;
  logic        awready, wready, bvalid, arready, rvalid, avg_valid;
  logic [7:0]  awaddr, araddr, mag_level, avg_level;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, lna2_gain;
  logic [4:0]  vga_gain;
  logic        flr, cl, hy, off;
  int          g, start, refup, dn, pend, sw, n, cyc;
  int          miscompares, check_count;

  rgc_gain_loop dut_u (
    .clk(clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .rx_on(rx_on), .mag_valid(mag_valid), .mag_level(mag_level),
    .vga_gain(vga_gain), .lna2_gain(lna2_gain), .avg_level(avg_level),
    .avg_valid(avg_valid)
  );

  always #50 clk = ~clk;

  task automatic finish_test();
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Bounds the whole run; the full test needs about 1000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic check_bus(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t bus got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_out(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t output got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && t < 50);
    check_bus({31'h0, bvalid}, 32'h1);
    check_bus({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && t < 50);
    check_bus({31'h0, rvalid}, 32'h1);
    check_bus(rdata, ed);
    check_bus({30'h0, rresp}, {30'h0, er});
  endtask

  function automatic logic [1:0] exp_lna(int gv);
    int th;
    th = (sw == 0) ? 0 : (sw == 1) ? 10 : (sw == 2) ? 19 : 32;
    if (gv >= th)
      return cl ? 2'h2 : 2'h1;
    return flr ? 2'h1 : 2'h0;
  endfunction

  // Writes all three registers, then cycles rx_on so the gain restarts
  task automatic cfg(input logic [7:0] s, input logic [7:0] st,
                     input logic [7:0] rf);
    {flr, cl} = s[7:6];
    sw = s[5:4];
    {off, hy} = s[3:2];
    n = 2 << s[1:0];
    dn = st[7:5];
    start = st[4:0];
    refup = rf[7:5] + rf[4:0];
    wr_chk(A_SETUP, {24'h0, s}, OK);
    wr_chk(A_STEP, {24'h0, st}, OK);
    wr_chk(A_REF, {24'h0, rf}, OK);
    rd_chk(A_STEP, {24'h0, st}, OK);
    @(posedge clk);
    rx_on <= 1'b0;
    @(posedge clk);
    rx_on <= 1'b1;
    @(posedge clk);
    #1;
    g = start;
    pend = 0;
    check_out(vga_gain, g);
    check_out(lna2_gain, exp_lna(g));
  endtask

  task automatic win(input int lo, input int hi);
    int sum, v, t, call;
    sum = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      v = $urandom_range(hi, lo);
      sum += v;
      mag_valid <= 1'b1;
      mag_level <= 8'(v);
    end
    @(posedge clk);
    mag_valid <= 1'b0;
    // The average pulse stands in the cycle of the last sample's edge
    #1;
    t = 0;
    while (!avg_valid && t < 10) begin
      @(posedge clk);
      #1;
      t++;
    end
    check_out({31'h0, avg_valid}, 32'h1);
    check_out(avg_level, sum / n);
    v = sum / n;
    call = (v < refup) ? 1 : (v > refup + 3 + dn) ? -1 : 0;
    // A call that the gain limits block counts as no call
    if ((call == 1 && g >= start) || (call == -1 && g == 0))
      call = 0;
    if (hy) begin
      if (call == 0 || call == pend) begin
        pend = 0;
      end else begin
        pend = call;
        call = 0;
      end
    end
    if (call == 1 && g < start) g++;
    if (call == -1 && g > 0) g--;
    @(posedge clk);
    #1;
    check_out(vga_gain, g);
    check_out(lna2_gain, exp_lna(g));
  endtask

  initial begin
    clk = 0;
    resetn = 0;
    {awvalid, wvalid, arvalid, rx_on, mag_valid} = 5'h00;
    {bready, rready} = 2'h3;
    {awaddr, araddr, mag_level} = 24'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    miscompares = 0;
    check_count = 0;
    cyc = 0;
    void'($urandom(69));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    check_out(vga_gain, 24);
    check_out(lna2_gain, 2'h0);
    rd_chk(A_SETUP, 32'h75, OK);
    rd_chk(A_STEP, 32'h38, OK);
    rd_chk(A_REF, 32'h38, OK);
    rd_chk(8'h04, 32'h0, DEC);
    wr_chk(8'h08, 32'hFF, DEC);
    // Hysteresis on, loop left enabled
    cfg(8'h64, 8'h14, 8'h2A);
    win(60, 60);
    win(60, 60);
    win(12, 12);
    win(60, 60);
    wr_chk(A_SETUP, 32'h6C, OK);
    @(posedge clk);
    #1;
    check_out(vga_gain, 20);
    repeat (16) begin
      @(posedge clk);
      mag_valid <= 1'b1;
      mag_level <= 8'h3C;
    end
    @(posedge clk);
    mag_valid <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check_out(vga_gain, 20);
    // Status packs average, second-amp level and gain; writes are ignored
    rd_chk(A_STAT, (60 << 7) | (int'(exp_lna(20)) << 5) | 20, OK);
    wr_chk(A_STAT, 32'hFF, OK);
    rd_chk(A_STAT, (60 << 7) | (int'(exp_lna(20)) << 5) | 20, OK);
    // Code 3 is the long, most accurate window
    for (int c = 0; c < 4; c++) begin
      repeat (3) begin
        cfg({4'($urandom()), 2'h0, 2'(c)}, 8'($urandom()),
            8'($urandom()));
        repeat (6) win(0, 63);
      end
    end
    finish_test();
  end
endmodule
